// file: rtl/dsd_defs.svh
// Address map, field positions and widths for the data-space decoder
// Notes on behaviour
// - Program addresses are 12 bits from the program counter, 000h to FFFh.
// - Return stack keeps six 12-bit return addresses.
// - Sixty bytes of general RAM live at 084h to 0BFh beside core registers.
// - Addresses 00h to 3Fh go to the selected 64-byte RAM/EEPROM bank.
// - Reads of 40h to 7Fh return program memory bytes through the window.
// - Window sits anywhere in program memory on 64-byte steps.
// - Window address is window base above the six low data address bits.
// - Window base is write-only; no reads or bit operations by software.
// - Window base is undefined after reset; software loads it first.
// - Only window base bits 5 to 0 exist; bits 6 and 7 ignored.
// - Port data C0h-C2h, direction C4h-C6h, option CCh-CEh.
// - Converter D0h-D1h, timer prescaler, counter, status D2h-D4h.
// - Auto-reload timer D5h-D7h, watchdog D8h, reload/compare/load D9h-DBh.
// - Serial data, divider and mode registers at E0h, E1h, E2h.
// - Bank select at E8h, EEPROM control at EAh.
// - Interrupt option C8h and window base C9h are write-only locations.
// - Oscillator control DCh is write-only; accumulator at FFh.
// - With readout protection chosen, program memory is unreadable outside.
// - Bank select bit 4 maps the second RAM page into 00h to 3Fh.
// - Bank select is not cleared at reset; software writes it first.
`ifndef DSD_DEFS_SVH
`define DSD_DEFS_SVH

`define PC_W            12
`define STACK_DEPTH     6
`define STACK_PTR_W     3
`define WIN_BASE_W      6
`define WIN_OFS_W       6
`define RAM_WORDS       60
`define RAM_IDX_W       6

`define BANK_HI         2'h0
`define WINDOW_HI       2'h1
`define CORE_X          8'h80
`define CORE_W          8'h83
`define RAM_FIRST       8'h84
`define RAM_LAST        8'hBF
`define PORT_DATA_FIRST 8'hC0
`define PORT_DATA_LAST  8'hC2
`define PORT_DIR_FIRST  8'hC4
`define PORT_DIR_LAST   8'hC6
`define INT_OPTION      8'hC8
`define WIN_BASE_ADDR   8'hC9
`define PORT_OPT_FIRST  8'hCC
`define PORT_OPT_LAST   8'hCE
`define CONV_FIRST      8'hD0
`define CONV_LAST       8'hD1
`define TIMER_FIRST     8'hD2
`define TIMER_LAST      8'hD4
`define ART_MODE_FIRST  8'hD5
`define ART_MODE_LAST   8'hD7
`define WATCHDOG        8'hD8
`define ART_DATA_FIRST  8'hD9
`define ART_DATA_LAST   8'hDB
`define OSC_CTRL        8'hDC
`define MISC_REG        8'hDD
`define SER_DATA        8'hE0
`define SER_DIV         8'hE1
`define SER_MODE        8'hE2
`define BANK_SEL_ADDR   8'hE8
`define EE_CTRL         8'hEA
`define ACCUM           8'hFF

`define BANK_RAM2_BIT   4
`define BANK_EE1_BIT    1
`define BANK_EE0_BIT    0
`define UNSPEC_READ     8'hFF
`define PROT_READ       8'hFF

`endif

// file: rtl/dsd_pkg.sv
// Types shared by the data-space decoder modules
package dsd_pkg;
   typedef enum logic [2:0] {
      TGT_NONE,
      TGT_BANK,
      TGT_WINDOW,
      TGT_CORE,
      TGT_RAM,
      TGT_PERIPH,
      TGT_WO
   } target_t;
endpackage

// file: rtl/stack_if.sv
// Push/pop link between the decoder and its return-address stack
`timescale 1ns/1ps
`default_nettype none
`include "dsd_defs.svh"
interface stack_if;
   logic             push;
   logic             pop;
   logic [`PC_W-1:0] push_data;
   logic [`PC_W-1:0] top_data;
   modport owner (output push, output pop, output push_data, input top_data);
   modport store (input push, input pop, input push_data, output top_data);
endinterface
`default_nettype wire

// file: rtl/return_stack.sv
// Six-level return-address stack
`timescale 1ns/1ps
`default_nettype none
`include "dsd_defs.svh"
module return_stack (
   input  wire logic ref_clk,
   input  wire logic nrst,
   stack_if.store    stk
);
   logic [`PC_W-1:0]        entry [`STACK_DEPTH];
   logic [`STACK_PTR_W-1:0] depth;

   localparam logic [`STACK_PTR_W-1:0] FULL = `STACK_PTR_W'(`STACK_DEPTH);
   localparam logic [`STACK_PTR_W-1:0] ONE  = `STACK_PTR_W'(1);

   wire logic                    is_full  = (depth == FULL);
   wire logic                    is_empty = (depth == '0);
   // Full push overwrites the newest level; deeper nesting is lost anyway
   wire logic [`STACK_PTR_W-1:0] wr_slot  = is_full ? depth - ONE : depth;
   wire logic [`STACK_PTR_W-1:0] top_slot = is_empty ? '0 : depth - ONE;

   assign stk.top_data = entry[top_slot];

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         depth <= '0;
      end else if (stk.push && !is_full) begin
         depth <= depth + ONE;
      end else if (stk.pop && !stk.push && !is_empty) begin
         depth <= depth - ONE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (stk.push) begin
         entry[wr_slot] <= stk.push_data;
      end
   end
endmodule
`default_nettype wire

// file: rtl/data_space_decoder.sv
// Data-space decoder with program counter, data ROM window and general RAM
`timescale 1ns/1ps
`default_nettype none
`include "dsd_defs.svh"
module data_space_decoder
   import dsd_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             nrst,
   // Core data-space access
   input  wire logic [7:0]       core_addr,
   input  wire logic             core_rd,
   input  wire logic             core_wr,
   input  wire logic [7:0]       core_wdata,
   output logic      [7:0]       core_rdata,
   output logic                  core_rvalid,
   // Program counter control
   input  wire logic             pc_step,
   input  wire logic             pc_load,
   input  wire logic             pc_call,
   input  wire logic             pc_return,
   input  wire logic [`PC_W-1:0] pc_target,
   // Program memory port
   output logic      [`PC_W-1:0] prog_addr,
   input  wire logic [7:0]       prog_rdata,
   // External programmer read port
   input  wire logic             ext_rd,
   input  wire logic [`PC_W-1:0] ext_addr,
   input  wire logic             readout_protect,
   output logic      [7:0]       ext_rdata,
   output logic                  ext_rvalid,
   // Banked RAM/EEPROM region
   output logic      [5:0]       bank_addr,
   output logic                  bank_rd,
   output logic                  bank_wr,
   output logic                  bank_ram2,
   output logic                  bank_ee0,
   output logic                  bank_ee1,
   input  wire logic [7:0]       bank_rdata,
   // Core and peripheral registers
   output logic      [7:0]       reg_addr,
   output logic                  reg_rd,
   output logic                  reg_wr,
   output logic      [7:0]       reg_wdata,
   input  wire logic [7:0]       reg_rdata
);

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   // banked region
   wire logic hit_bank   = (core_addr[7:6] == `BANK_HI);
   wire logic hit_window = (core_addr[7:6] == `WINDOW_HI);
   wire logic hit_core   = (core_addr >= `CORE_X && core_addr <= `CORE_W) ||
                           (core_addr == `ACCUM);
   wire logic hit_ram    = (core_addr >= `RAM_FIRST) &&
                           (core_addr <= `RAM_LAST);

   wire logic hit_pdata = (core_addr >= `PORT_DATA_FIRST) &&
                          (core_addr <= `PORT_DATA_LAST);
   wire logic hit_pdir  = (core_addr >= `PORT_DIR_FIRST) &&
                          (core_addr <= `PORT_DIR_LAST);
   wire logic hit_popt  = (core_addr >= `PORT_OPT_FIRST) &&
                          (core_addr <= `PORT_OPT_LAST);
   wire logic hit_conv  = (core_addr >= `CONV_FIRST) &&
                          (core_addr <= `CONV_LAST);
   wire logic hit_timer = (core_addr >= `TIMER_FIRST) &&
                          (core_addr <= `TIMER_LAST);
   wire logic hit_artm  = (core_addr >= `ART_MODE_FIRST) &&
                          (core_addr <= `ART_MODE_LAST);
   wire logic hit_wdog  = (core_addr == `WATCHDOG);
   wire logic hit_artd  = (core_addr >= `ART_DATA_FIRST) &&
                          (core_addr <= `ART_DATA_LAST);
   wire logic hit_ser   = (core_addr == `SER_DATA) ||
                          (core_addr == `SER_DIV)  ||
                          (core_addr == `SER_MODE);
   wire logic hit_eectl = (core_addr == `EE_CTRL);
   wire logic hit_misc  = (core_addr == `MISC_REG);

   wire logic hit_periph = hit_pdata | hit_pdir | hit_popt | hit_conv |
                           hit_timer | hit_artm | hit_wdog | hit_artd |
                           hit_ser | hit_eectl | hit_misc;

   // write-only locations kept by peripherals outside
   wire logic hit_wo_fwd  = (core_addr == `INT_OPTION) ||
                            (core_addr == `OSC_CTRL);
   wire logic hit_winbase = (core_addr == `WIN_BASE_ADDR);
   wire logic hit_banksel = (core_addr == `BANK_SEL_ADDR);
   wire logic hit_wo      = hit_wo_fwd | hit_winbase | hit_banksel;

   target_t tgt;
   always_comb begin
      if (hit_bank) begin
         tgt = TGT_BANK;
      end else if (hit_window) begin
         tgt = TGT_WINDOW;
      end else if (hit_core) begin
         tgt = TGT_CORE;
      end else if (hit_ram) begin
         tgt = TGT_RAM;
      end else if (hit_periph) begin
         tgt = TGT_PERIPH;
      end else if (hit_wo) begin
         tgt = TGT_WO;
      end else begin
         tgt = TGT_NONE;
      end
   end

   // ------------------------------------------------------------------
   // Access qualifiers
   // ------------------------------------------------------------------
   // A simultaneous read and write request is treated as a write
   wire logic do_wr   = core_wr;
   wire logic do_rd   = core_rd & ~core_wr;
   wire logic win_rd  = do_rd & (tgt == TGT_WINDOW);
   wire logic ram_rd  = do_rd & (tgt == TGT_RAM);
   // reserved addresses never reach a target
   wire logic fwd_rd  = do_rd & ((tgt == TGT_CORE) | (tgt == TGT_PERIPH));
   wire logic fwd_wr  = do_wr & ((tgt == TGT_CORE) | (tgt == TGT_PERIPH) |
                                 hit_wo_fwd);
   wire logic bsel_wr = do_wr & hit_banksel;
   wire logic wb_wr   = do_wr & hit_winbase;
   wire logic ram_wr  = do_wr & (tgt == TGT_RAM);

   // ------------------------------------------------------------------
   // Window base and bank select
   // ------------------------------------------------------------------
   // No reset: contents are undefined until software loads them
   logic [`WIN_BASE_W-1:0] rom_window_base;

   always_ff @(posedge ref_clk) begin
      if (wb_wr) begin
         rom_window_base <= core_wdata[`WIN_BASE_W-1:0];
      end
   end

   // base picks a 64-byte step; concatenated above data offset
   wire logic [`PC_W-1:0] win_prog_addr = {rom_window_base,
                                           core_addr[`WIN_OFS_W-1:0]};

   // page bits of the bank select register drive the bank lines
   // not cleared by reset; software loads it before banked use
   always_ff @(posedge ref_clk) begin
      if (bsel_wr) begin
         bank_ram2 <= core_wdata[`BANK_RAM2_BIT];
         bank_ee0  <= core_wdata[`BANK_EE0_BIT];
         bank_ee1  <= core_wdata[`BANK_EE1_BIT];
      end
   end

   // ------------------------------------------------------------------
   // Program counter and return stack
   // ------------------------------------------------------------------
   stack_if stk ();

   return_stack u_stack (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .stk     (stk)
   );

   localparam logic [`PC_W-1:0] PC_ONE = `PC_W'(1);

   logic [`PC_W-1:0] pc;
   logic [`PC_W-1:0] next_pc;

   always_comb begin
      if (pc_return) begin
         next_pc = stk.top_data;
      end else if (pc_call || pc_load) begin
         next_pc = pc_target;
      end else if (pc_step) begin
         next_pc = pc + PC_ONE;
      end else begin
         next_pc = pc;
      end
   end

   // calls save the address after the current one
   assign stk.push      = pc_call & ~pc_return;
   assign stk.pop       = pc_return;
   assign stk.push_data = pc + PC_ONE;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pc <= '0;
      end else begin
         pc <= next_pc;
      end
   end

   // ------------------------------------------------------------------
   // Program memory port arbitration
   // ------------------------------------------------------------------
   // Core window reads win; the programmer port takes any other slot, ahead of the next_pc fetch
   wire logic ext_grant = ext_rd & ~win_rd;

   logic [`PC_W-1:0] next_prog_addr;
   always_comb begin
      if (win_rd) begin
         next_prog_addr = win_prog_addr;
      end else if (ext_grant) begin
         next_prog_addr = ext_addr;
      end else begin
         next_prog_addr = next_pc;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prog_addr <= '0;
      end else begin
         prog_addr <= next_prog_addr;
      end
   end

   // Protection strap comes from outside this clock
   logic prot_meta;
   logic prot_sync;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prot_meta <= 1'b1;
         prot_sync <= 1'b1;
      end else begin
         prot_meta <= readout_protect;
         prot_sync <= prot_meta;
      end
   end

   logic ext_pend;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ext_pend   <= 1'b0;
         ext_rvalid <= 1'b0;
         ext_rdata  <= `PROT_READ;
      end else begin
         ext_pend   <= ext_grant;
         ext_rvalid <= ext_pend;
         if (ext_pend) begin
            ext_rdata <= prot_sync ? `PROT_READ : prog_rdata;
         end
      end
   end

   // ------------------------------------------------------------------
   // General RAM
   // ------------------------------------------------------------------
   logic [7:0] ram [`RAM_WORDS];
   logic [7:0] ram_q;

   localparam logic [7:0] RAM_BASE = `RAM_FIRST;
   wire logic [7:0]            ram_off = core_addr - RAM_BASE;
   wire logic [`RAM_IDX_W-1:0] ram_idx = ram_off[`RAM_IDX_W-1:0];

   always_ff @(posedge ref_clk) begin
      if (ram_wr) begin
         ram[ram_idx] <= core_wdata;
      end
      if (ram_rd) begin
         ram_q <= ram[ram_idx];
      end
   end

   // ------------------------------------------------------------------
   // Strobes to the bank region and the registers
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bank_addr <= '0;
         bank_rd   <= 1'b0;
         bank_wr   <= 1'b0;
         reg_addr  <= '0;
         reg_rd    <= 1'b0;
         reg_wr    <= 1'b0;
         reg_wdata <= '0;
      end else begin
         // offset within the selected 64-byte bank
         bank_addr <= core_addr[5:0];
         bank_rd   <= do_rd & (tgt == TGT_BANK);
         bank_wr   <= do_wr & (tgt == TGT_BANK);
         // write-only locations receive no read strobe
         reg_addr  <= core_addr;
         reg_rd    <= fwd_rd;
         reg_wr    <= fwd_wr;
         reg_wdata <= core_wdata;
      end
   end

   // ------------------------------------------------------------------
   // Read return
   // ------------------------------------------------------------------
   logic    rd_pend;
   target_t rd_tgt;
   logic [7:0] next_rdata;

   always_comb begin
      unique case (rd_tgt)
         TGT_BANK:           next_rdata = bank_rdata;
         // window bytes come from program memory
         TGT_WINDOW:         next_rdata = prog_rdata;
         TGT_RAM:            next_rdata = ram_q;
         TGT_CORE,
         TGT_PERIPH:         next_rdata = reg_rdata;
         // write-only and reserved reads give a fixed filler
         TGT_WO,
         TGT_NONE:           next_rdata = `UNSPEC_READ;
         default:            next_rdata = `UNSPEC_READ;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rd_pend     <= 1'b0;
         rd_tgt      <= TGT_NONE;
         core_rvalid <= 1'b0;
         core_rdata  <= '0;
      end else begin
         rd_pend     <= do_rd;
         rd_tgt      <= do_rd ? tgt : TGT_NONE;
         core_rvalid <= rd_pend;
         if (rd_pend) begin
            core_rdata <= next_rdata;
         end
      end
   end

endmodule
`default_nettype wire

// file: testbench/dsd_checker_properties.sv
// Port-level checks for the data-space decoder
`timescale 1ns/1ps
`default_nettype none
`include "dsd_defs.svh"
module dsd_checker (
   input wire logic             ref_clk,
   input wire logic             nrst,
   input wire logic [7:0]       core_addr,
   input wire logic             core_rd,
   input wire logic             core_wr,
   input wire logic [7:0]       core_wdata,
   input wire logic [7:0]       core_rdata,
   input wire logic             core_rvalid,
   input wire logic [`PC_W-1:0] prog_addr,
   input wire logic             readout_protect,
   input wire logic [7:0]       ext_rdata,
   input wire logic             ext_rvalid,
   input wire logic [5:0]       bank_addr,
   input wire logic             bank_rd,
   input wire logic             bank_wr,
   input wire logic             bank_ram2,
   input wire logic             reg_rd,
   input wire logic             reg_wr
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   // -------------------------------------------------
   // Request decode
   // -------------------------------------------------
   wire rd_only = core_rd && !core_wr;
   wire in_bank = core_addr[7:6] == 2'h0;
   wire in_win  = core_addr[7:6] == 2'h1;
   wire wo_loc  = core_addr inside {8'hC8, 8'hC9, 8'hDC, 8'hE8};

   // -------------------------------------------------
   // Assertions
   // -------------------------------------------------
   read_answer_a: assert property (rd_only |-> ##2 core_rvalid)
      else $error("read not answered after two cycles");
   answer_cause_a: assert property (core_rvalid |-> $past(rd_only, 2))
      else $error("read answer without a read");
   window_addr_a: assert property (rd_only && in_win |=>
      prog_addr[5:0] == $past(core_addr[5:0])) else $error("window offset");
   bank_read_a: assert property (rd_only && in_bank |=>
      bank_rd && bank_addr == $past(core_addr[5:0])) else $error("bank read");
   bank_write_a: assert property (core_wr && in_bank |=> bank_wr)
      else $error("bank write strobe missing");
   window_write_a: assert property (core_wr && in_win |=>
      !bank_wr && !reg_wr) else $error("window write not ignored");
   wo_read_a: assert property (rd_only && wo_loc |=>
      !reg_rd ##1 core_rdata == 8'hFF) else $error("write-only read");
   page_bit_a: assert property (core_wr && core_addr == 8'hE8 |=>
      bank_ram2 == $past(core_wdata[4])) else $error("page bit");
   port_read_a: assert property (rd_only && core_addr inside
      {[8'hC0:8'hC2]} |=> reg_rd) else $error("port read strobe");
   protect_read_a: assert property (readout_protect [*5] ##0
      ext_rvalid |-> ext_rdata == 8'hFF) else $error("protected byte out");

   cover property (rd_only && in_win);
   cover property (bank_rd);
   cover property (ext_rvalid && !readout_protect);
endmodule

bind data_space_decoder dsd_checker u_dsd_checker (
   .ref_clk(ref_clk), .nrst(nrst), .core_addr(core_addr),
   .core_rd(core_rd), .core_wr(core_wr), .core_wdata(core_wdata),
   .core_rdata(core_rdata), .core_rvalid(core_rvalid),
   .prog_addr(prog_addr), .readout_protect(readout_protect),
   .ext_rdata(ext_rdata), .ext_rvalid(ext_rvalid), .bank_addr(bank_addr),
   .bank_rd(bank_rd), .bank_wr(bank_wr), .bank_ram2(bank_ram2),
   .reg_rd(reg_rd), .reg_wr(reg_wr));
`default_nettype wire

// file: testbench/dsd_far_side.sv
// Program memory, banked memory and register file behind the decoder
`timescale 1ns/1ps
`default_nettype none
`include "dsd_defs.svh"
module dsd_far_side (
   input  wire logic [`PC_W-1:0] prog_addr,
   output logic      [7:0]       prog_rdata,
   input  wire logic [5:0]       bank_addr,
   input  wire logic             bank_ram2,
   output logic      [7:0]       bank_rdata,
   input  wire logic [7:0]       reg_addr,
   output logic      [7:0]       reg_rdata
);
   assign prog_rdata = (prog_addr < 12'h080) ? 8'hFF :
                       prog_addr[7:0] ^ {4'h0, prog_addr[11:8]};
   // Page bit folded in so a wrong page shows in the data
   assign bank_rdata = {1'b1, bank_ram2, bank_addr};
   assign reg_rdata  = reg_addr ^ 8'h5A;
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the data-space decoder
`timescale 1ns/1ps
`default_nettype none
`include "dsd_defs.svh"
module testbench;
   logic        ref_clk, nrst, core_rd, core_wr, core_rvalid;
   logic [7:0]  core_addr, core_wdata, core_rdata, prog_rdata, ext_rdata;
   logic        pc_step, pc_load, pc_call, pc_return, ext_rd, readout_protect;
   logic [11:0] pc_target, prog_addr, ext_addr, wr_seen;
   logic        bank_ee0, bank_ee1;
   logic        ext_rvalid, bank_rd, bank_wr, bank_ram2, reg_rd, reg_wr;
   logic [5:0]  bank_addr;
   logic [7:0]  bank_rdata, reg_addr, reg_wdata, reg_rdata;
   int          num_errors = 0;
   int          samples_checked = 0;

   data_space_decoder u_data_space_decoder (
      .ref_clk(ref_clk), .nrst(nrst), .core_addr(core_addr),
      .core_rd(core_rd), .core_wr(core_wr), .core_wdata(core_wdata),
      .core_rdata(core_rdata), .core_rvalid(core_rvalid),
      .pc_step(pc_step), .pc_load(pc_load), .pc_call(pc_call),
      .pc_return(pc_return), .pc_target(pc_target),
      .prog_addr(prog_addr), .prog_rdata(prog_rdata), .ext_rd(ext_rd),
      .ext_addr(ext_addr), .readout_protect(readout_protect),
      .ext_rdata(ext_rdata), .ext_rvalid(ext_rvalid),
      .bank_addr(bank_addr), .bank_rd(bank_rd), .bank_wr(bank_wr),
      .bank_ram2(bank_ram2), .bank_ee0(bank_ee0), .bank_ee1(bank_ee1),
      .bank_rdata(bank_rdata), .reg_addr(reg_addr), .reg_rd(reg_rd),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   dsd_far_side u_dsd_far_side (
      .prog_addr(prog_addr), .prog_rdata(prog_rdata),
      .bank_addr(bank_addr), .bank_ram2(bank_ram2),
      .bank_rdata(bank_rdata), .reg_addr(reg_addr), .reg_rdata(reg_rdata));

   // -------------------------------------------------
   // Expectations and reporting
   // -------------------------------------------------
   function automatic logic [11:0] exp_prog(input logic [11:0] a);
      return (a < 12'h080) ? 12'h0FF : {4'h0, a[7:0] ^ {4'h0, a[11:8]}};
   endfunction

   function automatic logic [11:0] exp_reg(input logic [7:0] a);
      logic ok;
      ok = a inside {[8'h80:8'h83], [8'hC0:8'hC2], [8'hC4:8'hC6],
           [8'hCC:8'hCE], [8'hD0:8'hDB], 8'hDD, [8'hE0:8'hE2], 8'hEA, 8'hFF};
      return ok ? {4'h0, a ^ 8'h5A} : 12'h0FF;
   endfunction

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // -------------------------------------------------
   // Bus tasks
   // -------------------------------------------------
   task automatic core_write(input logic [7:0] a, input logic [7:0] d);
      core_addr = a;
      core_wdata = d;
      core_wr = 1'b1;
      @(negedge ref_clk);
      core_wr = 1'b0;
      wr_seen = {2'b00, bank_wr, reg_wr, reg_wdata};
      @(negedge ref_clk);
   endtask

   task automatic core_read(input logic [7:0] a, output logic [11:0] d);
      int n;
      core_addr = a;
      core_rd = 1'b1;
      @(negedge ref_clk);
      core_rd = 1'b0;
      n = 0;
      while (core_rvalid !== 1'b1 && n < 4) begin
         @(negedge ref_clk);
         n++;
      end
      check({11'h0, n < 4}, 12'h001);
      if (n == 4)
         tally_and_finish();
      d = {4'h0, core_rdata};
   endtask

   task automatic ext_read(input logic [11:0] a, output logic [11:0] d);
      int n;
      ext_addr = a;
      ext_rd = 1'b1;
      @(negedge ref_clk);
      ext_rd = 1'b0;
      n = 0;
      while (ext_rvalid !== 1'b1 && n < 4) begin
         @(negedge ref_clk);
         n++;
      end
      check({11'h0, n < 4}, 12'h001);
      if (n == 4)
         tally_and_finish();
      d = {4'h0, ext_rdata};
   endtask

   task automatic pc_op(input int k, input logic [11:0] t,
                        input logic [11:0] exp);
      pc_target = t;
      pc_load = (k == 0);
      pc_call = (k == 1);
      pc_return = (k == 2);
      pc_step = (k == 3);
      @(negedge ref_clk);
      {pc_step, pc_load, pc_call, pc_return} = 4'h0;
      check(prog_addr, exp);
      @(negedge ref_clk);
   endtask

   // -------------------------------------------------
   // Scenarios
   // -------------------------------------------------
   task automatic window_reads();
      logic [11:0] d;
      core_write(8'hC9, 8'hE8);
      check(wr_seen, 12'h0E8);
      core_write(8'h59, 8'h00);
      check(wr_seen, 12'h000);
      core_read(8'h59, d);
      check(d, exp_prog(12'hA19));
      core_write(8'hC9, 8'h3F);
      core_read(8'h7F, d);
      check(d, exp_prog(12'hFFF));
      core_write(8'hC9, 8'h00);
      core_read(8'h40, d);
      check(d, exp_prog(12'h040));
   endtask

   task automatic ram_rw();
      logic [11:0] d;
      core_write(8'h84, 8'hA5);
      core_write(8'hBF, 8'h3C);
      core_read(8'h84, d);
      check(d, 12'h0A5);
      core_read(8'hBF, d);
      check(d, 12'h03C);
   endtask

   task automatic bank_page();
      logic [11:0] d;
      core_write(8'hE8, 8'h10);
      check({11'h0, bank_ram2}, 12'h001);
      core_read(8'h10, d);
      check(d, 12'h0D0);
      core_write(8'hE8, 8'h00);
      check({11'h0, bank_ram2}, 12'h000);
      core_read(8'h3F, d);
      check(d, 12'h0BF);
      core_write(8'h10, 8'h55);
      check(wr_seen, 12'h255);
      core_write(8'hE8, 8'h02);
      check({9'h0, bank_ee1, bank_ee0, bank_ram2}, 12'h004);
   endtask

   task automatic map_reads();
      logic [11:0] d;
      core_write(8'hD3, 8'h66);
      check(wr_seen, 12'h166);
      core_write(8'hC8, 8'h11);
      check(wr_seen, 12'h111);
      core_write(8'hC3, 8'h22);
      check(wr_seen, 12'h022);
      for (int a = 128; a < 256; a++) begin
         if (a > 131 && a < 192)
            continue;
         core_read(8'(a), d);
         check(d, exp_reg(8'(a)));
      end
   endtask

   task automatic readout_guard();
      logic [11:0] d;
      readout_protect = 1'b0;
      repeat (4) @(negedge ref_clk);
      ext_read(12'h5A7, d);
      check(d, exp_prog(12'h5A7));
      readout_protect = 1'b1;
      repeat (4) @(negedge ref_clk);
      ext_read(12'h5A7, d);
      check(d, 12'h0FF);
   endtask

   task automatic stack_depth();
      logic [11:0] q[$];
      logic [11:0] pc;
      pc_op(0, 12'hFFF, 12'hFFF);
      pc_op(3, 12'h000, 12'h000);
      pc = 12'h100;
      pc_op(0, pc, pc);
      for (int i = 0; i < 6; i++) begin
         q.push_back(pc + 12'h001);
         pc = 12'h200 + 12'(16 * i);
         pc_op(1, pc, pc);
      end
      for (int i = 0; i < 6; i++)
         pc_op(2, 12'h000, q.pop_back());
   endtask

   // -------------------------------------------------
   // Clock, reset and sequence
   // -------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   initial begin
      nrst = 1'b0;
      {core_rd, core_wr, pc_step, pc_load, pc_call, pc_return} = 6'h00;
      {core_addr, core_wdata} = 16'h0000;
      {pc_target, ext_addr} = 24'h000000;
      ext_rd = 1'b0;
      readout_protect = 1'b1;
      repeat (10) @(negedge ref_clk);
      nrst = 1'b1;
      @(negedge ref_clk);
      window_reads();
      ram_rw();
      bank_page();
      map_reads();
      readout_guard();
      stack_depth();
      tally_and_finish();
   end
endmodule
`default_nettype wire
